// ---- hdl/tmc_transfer_mode_control.sv ----
// Transfer mode control: registers, automatic count command, data start
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns

module tmc_transfer_mode_control #(
	parameter int unsigned SPEC_VERSION = 2,
	parameter int unsigned COUNT_W      = 16
) (
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output      logic                  hreadyout,
	output      logic                  hresp,
	output      logic [31:0]           hrdata,
	// Capability strap
	input  wire logic                  cap_dma_support,
	// Card command issue
	output      logic                  cmd_valid,
	output      tmc_pkg::tmc_cmd_req_t cmd_req,
	input  wire logic                  cmd_ready,
	input  wire logic                  rsp_valid,
	input  wire logic                  rsp_err,
	// Data transfer start and end
	output      logic                  xfer_start,
	output      tmc_pkg::tmc_xfer_req_t xfer_req,
	input  wire logic                  data_done,
	// Status
	output      logic                  data_line_inhibit,
	output      logic                  cmd23_error
);
	import tmc_pkg::*;

	// Elaboration refuses setups the logic cannot serve
	if (SPEC_VERSION < 2)
		$error("Automatic count command needs version 3.00 or later");
	if (COUNT_W != 16)
		$error("Block count width must be 16");

	// Bus address phase capture
	logic        ap_valid;
	logic        dp_wr_r;
	logic [7:0]  dp_addr_r;
	logic [31:0] rdata_r;

	assign ap_valid  = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;

	// Registers
	logic [TMC_TM_W-1:0]     tmode_r;
	logic [TMC_CMD_W-1:0]    cmd_r;
	logic [31:0]             arg2_r;
	logic [31:0]             arg1_r;
	logic [COUNT_W-1:0]      blkcnt_r;
	logic [7:0]              hctl1_r;
	logic                    dinh_r;
	logic                    aerr_r;
	tmc_state_t              state_r;
	tmc_state_t              state_nxt;
	tmc_cmd_req_t            cmd_req_r;
	logic                    xfer_start_r;
	tmc_xfer_req_t           xfer_req_r;

	// Write decode
	logic wr_tmode;
	logic wr_cmd;
	logic wr_arg1;
	logic wr_arg2;
	logic wr_blkcnt;
	logic wr_hctl1;
	logic wr_aerr;
	logic bus_wr;

	assign bus_wr    = dp_wr_r;
	assign wr_tmode  = bus_wr & (dp_addr_r == TMC_OFF_TMODE) & ~dinh_r;
	assign wr_cmd    = bus_wr & (dp_addr_r == TMC_OFF_CMD)
		& (state_r == TMC_S_IDLE);
	assign wr_arg1   = bus_wr & (dp_addr_r == TMC_OFF_ARG1);
	assign wr_arg2   = bus_wr & (dp_addr_r == TMC_OFF_ARG2);
	assign wr_blkcnt = bus_wr & (dp_addr_r == TMC_OFF_BLKCNT);
	assign wr_hctl1  = bus_wr & (dp_addr_r == TMC_OFF_HCTL1);
	assign wr_aerr   = bus_wr & (dp_addr_r == TMC_OFF_AERR);

	// Transfer mode fields
	logic       tm_dma;
	logic       tm_bcen;
	logic [1:0] tm_acmd;
	logic       tm_read;
	logic       tm_multi;

	// DMA bit has no effect without the capability
	assign tm_dma   = tmode_r[TMC_TM_DMA] & cap_dma_support;
	assign tm_bcen  = tmode_r[TMC_TM_BCEN];
	assign tm_acmd  = tmode_r[TMC_TM_ACMD +: 2];
	assign tm_read  = tmode_r[TMC_TM_DIR];
	assign tm_multi = tmode_r[TMC_TM_MULTI];

	// Written command word fields
	logic [5:0] new_idx;
	logic       new_dps;
	logic       cmd_dps;
	logic       auto23;
	logic       auto12;

	assign new_idx = hwdata[TMC_CMD_IDX +: TMC_CMD_IDX_W];
	assign new_dps = hwdata[TMC_CMD_DPS];
	assign cmd_dps = cmd_r[TMC_CMD_DPS];
	// No index check: any command may follow the count command
	assign auto23  = (tm_acmd == TMC_ACMD_23);
	assign auto12  = (tm_acmd == TMC_ACMD_12);

	// Transfer classification
	tmc_xfer_kind_t kind;
	logic           cnt_zero;

	assign cnt_zero = (blkcnt_r == '0);
	assign kind = !tm_multi ? TMC_XT_SINGLE :
		!tm_bcen ? TMC_XT_INFINITE :
		cnt_zero ? TMC_XT_STOP : TMC_XT_MULTIPLE;

	// Read mux
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign status_word = {28'h000_0000, kind, (state_r != TMC_S_IDLE),
		dinh_r};
	always_comb begin
		rd_mux = TMC_RST_WORD;
		case (haddr[7:0])
			TMC_OFF_TMODE:
				rd_mux = {26'h000_0000, tmode_r[TMC_TM_W-1:1], tm_dma};
			TMC_OFF_CMD:    rd_mux = {18'h0_0000, cmd_r};
			TMC_OFF_ARG2:   rd_mux = arg2_r;
			TMC_OFF_BLKCNT: rd_mux = {16'h0000, blkcnt_r};
			TMC_OFF_HCTL1:  rd_mux = {24'h00_0000, hctl1_r};
			TMC_OFF_STATUS: rd_mux = status_word;
			TMC_OFF_AERR:   rd_mux = {31'h0000_0000, aerr_r};
			TMC_OFF_ARG1:   rd_mux = arg1_r;
			default:        rd_mux = TMC_RST_WORD;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r   <= 1'b0;
			dp_addr_r <= 8'h00;
			rdata_r   <= TMC_RST_WORD;
		end else begin
			dp_wr_r   <= ap_valid & hwrite;
			dp_addr_r <= haddr[7:0];
			if (ap_valid && !hwrite)
				rdata_r <= rd_mux;
		end
	end

	// Software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmode_r  <= '0;
			cmd_r    <= '0;
			arg1_r   <= TMC_RST_WORD;
			arg2_r   <= TMC_RST_WORD;
			blkcnt_r <= TMC_RST_HALF;
			hctl1_r  <= 8'h00;
		end else begin
			if (wr_tmode)
				tmode_r <= hwdata[TMC_TM_W-1:0];
			if (wr_cmd)
				cmd_r <= hwdata[TMC_CMD_W-1:0];
			if (wr_arg1)
				arg1_r <= hwdata;
			if (wr_arg2)
				arg2_r <= hwdata;
			if (wr_blkcnt)
				blkcnt_r <= hwdata[COUNT_W-1:0];
			if (wr_hctl1)
				hctl1_r <= hwdata[7:0];
		end
	end

	// Command sequencer
	logic rsp_ok;
	logic rsp_bad;
	logic suppress;
	logic cmd_done_ok;

	assign rsp_ok      = rsp_valid & ~rsp_err;
	assign rsp_bad     = rsp_valid & rsp_err;
	assign suppress    = (state_r == TMC_S_W23) & rsp_bad;
	assign cmd_done_ok = (state_r == TMC_S_WCMD) & rsp_ok;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			TMC_S_IDLE:
				if (wr_cmd)
					state_nxt = auto23 ? TMC_S_C23 : TMC_S_CMD;
			TMC_S_C23:
				if (cmd_ready)
					state_nxt = TMC_S_W23;
			TMC_S_W23:
				if (rsp_bad)
					state_nxt = TMC_S_IDLE;
				else if (rsp_ok)
					state_nxt = TMC_S_CMD;
			TMC_S_CMD:
				if (cmd_ready)
					state_nxt = TMC_S_WCMD;
			TMC_S_WCMD:
				if (rsp_valid)
					state_nxt = TMC_S_IDLE;
			default:
				state_nxt = TMC_S_IDLE;
		endcase
	end

	assign cmd_valid = (state_r == TMC_S_C23) | (state_r == TMC_S_CMD);
	assign cmd_req   = cmd_req_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r   <= TMC_S_IDLE;
			cmd_req_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (state_r == TMC_S_IDLE && wr_cmd) begin
				if (auto23) begin
					cmd_req_r.index    <= TMC_IDX_SET_COUNT;
					cmd_req_r.flags    <= 8'h00;
					cmd_req_r.arg      <= arg2_r;
					cmd_req_r.auto_cmd <= 1'b1;
				end else begin
					cmd_req_r.index    <= new_idx;
					cmd_req_r.flags    <= hwdata[7:0];
					cmd_req_r.arg      <= arg1_r;
					cmd_req_r.auto_cmd <= 1'b0;
				end
			end else if (state_r == TMC_S_W23 && rsp_ok) begin
				cmd_req_r.index    <= cmd_r[TMC_CMD_IDX +: TMC_CMD_IDX_W];
				cmd_req_r.flags    <= cmd_r[7:0];
				cmd_req_r.arg      <= arg1_r;
				cmd_req_r.auto_cmd <= 1'b0;
			end
		end
	end

	// Data start after the programmed command completes cleanly
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xfer_start_r <= 1'b0;
			xfer_req_r   <= '0;
		end else begin
			xfer_start_r <= cmd_done_ok & cmd_dps;
			if (cmd_done_ok) begin
				xfer_req_r.dma     <= tm_dma;
				xfer_req_r.variant <= hctl1_r[TMC_HC_VAR +: TMC_HC_VAR_W];
				xfer_req_r.read    <= tm_read;
				xfer_req_r.kind    <= kind;
				xfer_req_r.count   <= blkcnt_r;
				xfer_req_r.auto12  <= auto12;
			end
		end
	end

	assign xfer_start = xfer_start_r;
	assign xfer_req   = xfer_req_r;

	// Inhibit covers the whole data command; a failed response also frees it
	logic dinh_set;
	logic dinh_clr;

	assign dinh_set = wr_cmd & new_dps;
	assign dinh_clr = data_done | suppress
		| ((state_r == TMC_S_WCMD) & rsp_bad)
		| ((state_r == TMC_S_WCMD) & rsp_ok & ~cmd_dps);

	// Error flag: write one clears, a new error in the same cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dinh_r <= 1'b0;
			aerr_r <= 1'b0;
		end else begin
			if (dinh_set)
				dinh_r <= 1'b1;
			else if (dinh_clr)
				dinh_r <= 1'b0;
			if (suppress)
				aerr_r <= 1'b1;
			else if (wr_aerr && hwdata[TMC_AE_C23])
				aerr_r <= 1'b0;
		end
	end

	assign data_line_inhibit = dinh_r;
	assign cmd23_error       = aerr_r;

endmodule

// ---- common/tmc_pkg.sv ----
// Shared constants and types for the transfer mode control block
package tmc_pkg;

	// Register byte offsets on the AHB-Lite bus
	localparam logic [7:0] TMC_OFF_TMODE  = 8'h00;
	localparam logic [7:0] TMC_OFF_CMD    = 8'h04;
	localparam logic [7:0] TMC_OFF_ARG2   = 8'h08;
	localparam logic [7:0] TMC_OFF_BLKCNT = 8'h0C;
	localparam logic [7:0] TMC_OFF_HCTL1  = 8'h10;
	localparam logic [7:0] TMC_OFF_STATUS = 8'h14;
	localparam logic [7:0] TMC_OFF_AERR   = 8'h18;
	localparam logic [7:0] TMC_OFF_ARG1   = 8'h1C;

	// Transfer mode field positions
	localparam int unsigned TMC_TM_DMA    = 0;
	localparam int unsigned TMC_TM_BCEN   = 1;
	localparam int unsigned TMC_TM_ACMD   = 2;
	localparam int unsigned TMC_TM_DIR    = 4;
	localparam int unsigned TMC_TM_MULTI  = 5;
	localparam int unsigned TMC_TM_W      = 6;

	// Command register field positions
	localparam int unsigned TMC_CMD_DPS   = 5;
	localparam int unsigned TMC_CMD_IDX   = 8;
	localparam int unsigned TMC_CMD_IDX_W = 6;
	localparam int unsigned TMC_CMD_W     = 14;

	// Host control 1 transfer-variant field
	localparam int unsigned TMC_HC_VAR    = 3;
	localparam int unsigned TMC_HC_VAR_W  = 2;

	// Status and automatic-command error bits
	localparam int unsigned TMC_ST_DINH   = 0;
	localparam int unsigned TMC_ST_BUSY   = 1;
	localparam int unsigned TMC_ST_KIND   = 2;
	localparam int unsigned TMC_AE_C23    = 0;

	// Automatic-command selection encodings
	localparam logic [1:0] TMC_ACMD_OFF   = 2'h0;
	localparam logic [1:0] TMC_ACMD_12    = 2'h1;
	localparam logic [1:0] TMC_ACMD_23    = 2'h2;

	localparam logic [5:0] TMC_IDX_SET_COUNT = 6'h17;

	// Reset values
	localparam logic [31:0] TMC_RST_WORD  = 32'h0000_0000;
	localparam logic [15:0] TMC_RST_HALF  = 16'h0000;

	typedef enum logic [1:0] {
		TMC_XT_SINGLE   = 2'h0,
		TMC_XT_INFINITE = 2'h1,
		TMC_XT_MULTIPLE = 2'h2,
		TMC_XT_STOP     = 2'h3
	} tmc_xfer_kind_t;

	// Gray along idle -> count -> wait -> command -> wait
	typedef enum logic [2:0] {
		TMC_S_IDLE  = 3'h0,
		TMC_S_C23   = 3'h1,
		TMC_S_W23   = 3'h3,
		TMC_S_CMD   = 3'h2,
		TMC_S_WCMD  = 3'h6
	} tmc_state_t;

	typedef struct packed {
		logic [5:0]  index;
		logic [7:0]  flags;
		logic [31:0] arg;
		logic        auto_cmd;
	} tmc_cmd_req_t;

	typedef struct packed {
		logic           dma;
		logic [1:0]     variant;
		logic           read;
		tmc_xfer_kind_t kind;
		logic [15:0]    count;
		logic           auto12;
	} tmc_xfer_req_t;

endpackage

// ---- sim/tmc_card_model.sv ----
// Behavioural card that answers commands and finishes data transfers
`timescale 1ns/1ns
module tmc_card_model (
	// Clock, reset and bench controls
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic [3:0]            delay,
	input  wire logic                  fail_auto,
	// Command link
	input  wire logic                  cmd_valid,
	input  wire tmc_pkg::tmc_cmd_req_t cmd_req,
	output      logic                  cmd_ready,
	output      logic                  rsp_valid,
	output      logic                  rsp_err,
	// Data and observation
	input  wire logic                  xfer_start,
	output      logic                  data_done,
	output      logic [31:0]           auto_arg,
	output      logic [5:0]            prog_idx,
	output      int                    taken
);
	import tmc_pkg::*;
	logic is_auto;
	initial begin
		{cmd_ready, rsp_valid, rsp_err} = 3'h0;
		auto_arg = 32'h0000_0000;
		prog_idx = 6'h00;
		taken = 0;
		forever begin
			@(posedge hclk);
			if (hresetn && cmd_valid) begin
				repeat (delay) @(posedge hclk);
				cmd_ready <= 1'b1;
				@(posedge hclk);
				cmd_ready <= 1'b0;
				is_auto = cmd_req.auto_cmd;
				taken = taken + 1;
				if (is_auto)
					auto_arg = cmd_req.arg;
				else
					prog_idx = cmd_req.index;
				repeat (delay) @(posedge hclk);
				rsp_valid <= 1'b1;
				// Count command accepted unless told to fail
				rsp_err <= fail_auto && is_auto;
				@(posedge hclk);
				rsp_valid <= 1'b0;
				// Unqualified error line shows noise, not a held value
				rsp_err <= ~rsp_err;
			end
		end
	end
	// One process owns the done line, reset value included
	initial begin
		data_done = 1'b0;
		forever begin
			@(posedge hclk);
			if (xfer_start) begin
				repeat (delay + 2) @(posedge hclk);
				data_done <= 1'b1;
				@(posedge hclk);
				data_done <= 1'b0;
			end
		end
	end
endmodule

// ---- sim/tmc_chk.sv ----
// Port checker for the transfer mode control block
`timescale 1ns/1ns
module tmc_chk (
	// Clock and reset
	input wire logic                   hclk,
	input wire logic                   hresetn,
	// Observed ports
	input wire logic                   cap_dma_support,
	input wire logic                   cmd_valid,
	input wire tmc_pkg::tmc_cmd_req_t  cmd_req,
	input wire logic                   cmd_ready,
	input wire logic                   rsp_valid,
	input wire logic                   rsp_err,
	input wire logic                   xfer_start,
	input wire tmc_pkg::tmc_xfer_req_t xfer_req,
	input wire logic                   cmd23_error
);
	import tmc_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic auto_out_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			auto_out_r <= 1'b0;
		else if (cmd_valid && cmd_ready)
			auto_out_r <= cmd_req.auto_cmd;
	end
	count_index_a: assert property (
		cmd_valid && cmd_req.auto_cmd |-> cmd_req.index == TMC_IDX_SET_COUNT)
		else $error("count command index wrong");
	cmd_hold_a: assert property (
		cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_req))
		else $error("command dropped before taken");
	second_cmd_a: assert property (
		rsp_valid && !rsp_err && auto_out_r
		|-> ##[1:4] (cmd_valid && !cmd_req.auto_cmd))
		else $error("programmed command missing");
	suppress_a: assert property (
		rsp_valid && rsp_err && auto_out_r
		|=> (!cmd_valid && !xfer_start) [*4])
		else $error("command or data after count error");
	err_flag_a: assert property (
		rsp_valid && rsp_err && auto_out_r |=> cmd23_error)
		else $error("count error not flagged");
	start_pulse_a: assert property (xfer_start |=> !xfer_start)
		else $error("start longer than one cycle");
	no_dma_a: assert property (
		xfer_start && !cap_dma_support |-> !xfer_req.dma)
		else $error("dma without capability");
	multi_count_a: assert property (
		xfer_start && xfer_req.kind == TMC_XT_MULTIPLE
		|-> xfer_req.count != 16'h0000)
		else $error("multiple with zero count");
	auto_c: cover property (cmd_valid && cmd_ready && cmd_req.auto_cmd);
	fail_c: cover property (rsp_valid && rsp_err && auto_out_r);
	dma_c: cover property (xfer_start && xfer_req.dma);
endmodule

bind tmc_transfer_mode_control tmc_chk i_tmc_chk (
	.hclk(hclk), .hresetn(hresetn), .cap_dma_support(cap_dma_support),
	.cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_ready(cmd_ready),
	.rsp_valid(rsp_valid), .rsp_err(rsp_err), .xfer_start(xfer_start),
	.xfer_req(xfer_req), .cmd23_error(cmd23_error)
);

// ---- sim/tmc_transfer_mode_control_test.sv ----
// Self-checking bench for the transfer mode control block
`timescale 1ns/1ns
module tmc_transfer_mode_control_test;
	import tmc_pkg::*;
	logic          hclk = 1'b0;
	logic          hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic          cap_dma_support, cmd_valid, cmd_ready, rsp_valid;
	logic          rsp_err, xfer_start, data_done, data_line_inhibit;
	logic          cmd23_error, fail_auto;
	logic [31:0]   haddr, hwdata, hrdata, auto_arg;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [3:0]    delay;
	logic [5:0]    prog_idx;
	tmc_cmd_req_t  cmd_req;
	tmc_xfer_req_t xfer_req;
	int            taken, err_count, checks;
	int            starts = 0;

	always #5 hclk = ~hclk;
	assign hready = hreadyout;
	always @(posedge hclk) if (xfer_start === 1'b1) starts++;

	tmc_transfer_mode_control i_tmc_transfer_mode_control (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .cap_dma_support, .cmd_valid, .cmd_req,
		.cmd_ready, .rsp_valid, .rsp_err, .xfer_start, .xfer_req, .data_done,
		.data_line_inhibit, .cmd23_error);
	tmc_card_model i_tmc_card_model (.hclk, .hresetn, .delay, .fail_auto,
		.cmd_valid, .cmd_req, .cmd_ready, .rsp_valid, .rsp_err, .xfer_start,
		.data_done, .auto_arg, .prog_idx, .taken);

	task automatic check(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic give_up(input logic bad);
		if (bad) begin
			err_count++;
			end_of_test();
		end
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		give_up(hreadyout !== 1'b1);
	endtask
	task automatic bus(input logic [7:0] a, input logic w,
			input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		wait_ready();
		{hsel, htrans} <= 3'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(a, 1'b0, 32'h0000_0000, d);
	endtask
	task automatic wait_start(input int want);
		int n;
		for (n = 0; n < 300 && starts < want; n++) @(posedge hclk);
		give_up(starts < want);
	endtask
	// Polls status until neither inhibit nor busy is set
	task automatic wait_free();
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			rd(TMC_OFF_STATUS, s);
			n++;
		end while (s[1:0] !== 2'h0 && n < 100);
		give_up(s[1:0] !== 2'h0);
	endtask

	task automatic t_reset();
		logic [31:0] d;
		rd(TMC_OFF_TMODE, d);
		check("mode reset", d, TMC_RST_WORD);
		rd(TMC_OFF_AERR, d);
		check("error reset", d, TMC_RST_WORD);
		rd(8'h40, d);
		check("unmapped", d, 32'h0000_0000);
		check("response", hresp, 1'b0);
	endtask
	task automatic t_kind();
		logic [31:0] d;
		logic [7:0] tm [4] = '{8'h02, 8'h20, 8'h22, 8'h22};
		logic [7:0] bc [4] = '{8'h05, 8'h00, 8'h03, 8'h00};
		for (int i = 0; i < 4; i++) begin
			wr(TMC_OFF_BLKCNT, {24'h00_0000, bc[i]});
			wr(TMC_OFF_TMODE, {24'h00_0000, tm[i]});
			rd(TMC_OFF_STATUS, d);
			check("kind", d[3:2], i);
		end
		wr(TMC_OFF_TMODE, 32'h0000_003D);
		rd(TMC_OFF_TMODE, d);
		check("dma off", d[0], 1'b0);
		check("mode bits", d[5:1], 5'h1E);
	endtask
	task automatic t_auto();
		logic [31:0] d;
		int n0, s0;
		cap_dma_support <= 1'b1;
		wr(TMC_OFF_ARG2, 32'h0001_2345);
		wr(TMC_OFF_ARG1, 32'h0000_0400);
		wr(TMC_OFF_BLKCNT, 32'h0000_0007);
		wr(TMC_OFF_HCTL1, 32'h0000_0010);
		wr(TMC_OFF_TMODE, 32'h0000_003B);
		n0 = taken;
		s0 = starts;
		wr(TMC_OFF_CMD, 32'h0000_1220);
		wr(TMC_OFF_TMODE, 32'h0000_0000);
		check("inhibit pin", data_line_inhibit, 1'b1);
		wait_start(s0 + 1);
		check("count", xfer_req.count, 16'h0007);
		check("count arg", auto_arg, 32'h0001_2345);
		check("commands", taken - n0, 2);
		check("prog index", prog_idx, 6'h12);
		check("dma", xfer_req.dma, 1'b1);
		check("variant", xfer_req.variant, 2'h2);
		check("read", xfer_req.read, 1'b1);
		check("kind", xfer_req.kind, TMC_XT_MULTIPLE);
		wait_free();
		rd(TMC_OFF_TMODE, d);
		check("mode kept", d[5:0], 6'h3B);
	endtask
	task automatic t_fail();
		logic [31:0] d;
		int n0, s0;
		fail_auto <= 1'b1;
		delay <= 4'h2;
		wr(TMC_OFF_TMODE, 32'h0000_002A);
		n0 = taken;
		s0 = starts;
		wr(TMC_OFF_CMD, 32'h0000_1120);
		wait_free();
		check("commands", taken - n0, 1);
		check("starts", starts, s0);
		check("error flag", cmd23_error, 1'b1);
		rd(TMC_OFF_AERR, d);
		check("error reg", d[0], 1'b1);
		wr(TMC_OFF_AERR, 32'h0000_0001);
		rd(TMC_OFF_AERR, d);
		check("error clear", d[0], 1'b0);
		fail_auto <= 1'b0;
	endtask
	task automatic t_modes();
		logic [7:0] tm [3] = '{8'h05, 8'h01, 8'h0D};
		int n0, s0;
		cap_dma_support <= 1'b0;
		delay <= 4'h3;
		for (int i = 0; i < 3; i++) begin
			wr(TMC_OFF_TMODE, {24'h00_0000, tm[i]});
			n0 = taken;
			s0 = starts;
			wr(TMC_OFF_CMD, 32'h0000_1820);
			wait_start(s0 + 1);
			check("commands", taken - n0, 1);
			check("auto stop", xfer_req.auto12, i == 0);
			check("dma", xfer_req.dma, 1'b0);
			check("kind", xfer_req.kind, TMC_XT_SINGLE);
			check("read", xfer_req.read, 1'b0);
			wait_free();
		end
	endtask

	initial begin
		{hresetn, hsel, hwrite, cap_dma_support, fail_auto} = 5'h00;
		{haddr, hwdata} = 64'h0000_0000_0000_0000;
		{htrans, delay} = 6'h00;
		hsize = 3'h2;
		err_count = 0;
		checks = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_kind();
		t_auto();
		t_fail();
		t_modes();
		end_of_test();
	end
endmodule
